// >>> rtl/dlc_cfg.svh
// Timing and field constants for the DAC write controller.
// Assumes a 200 MHz system clock; included by the rtl files only.
`ifndef DLC_CFG_SVH
`define DLC_CFG_SVH
`define DLC_CLK_PERIOD_NS   5
`define DLC_T_DATA_SETUP_NS 200
`define DLC_T_WR_LOW_NS     200
`define DLC_T_WR_HOLD_NS    5
`define DLC_SETUP_CYC       ((`DLC_T_DATA_SETUP_NS + `DLC_CLK_PERIOD_NS - 1) / `DLC_CLK_PERIOD_NS)
`define DLC_WRLOW_CYC       ((`DLC_T_WR_LOW_NS + `DLC_CLK_PERIOD_NS - 1) / `DLC_CLK_PERIOD_NS)
`define DLC_HOLD_CYC        ((`DLC_T_WR_HOLD_NS + `DLC_CLK_PERIOD_NS - 1) / `DLC_CLK_PERIOD_NS)
`define DLC_WORD_W          16
`define DLC_BYTE_W          8
`define DLC_MSB             15
`define DLC_CNT_W           8
`endif

// >>> rtl/dlc_pkg.sv
// Types for the DAC write controller.
// Assumes nothing beyond the config header.
`default_nettype none
package dlc_pkg;
  typedef enum logic [2:0] {
    DLC_IDLE  = 3'h0,
    DLC_SETUP = 3'h1,
    DLC_STRB  = 3'h3,
    DLC_HOLD  = 3'h2,
    DLC_DONE  = 3'h6
  } dlc_state_t;
endpackage
`default_nettype wire

// >>> rtl/dlc_assembler.sv
// Assembles a 16-bit word from two 8-bit bus writes, low byte first.
// Assumes byte strobes are one-cycle pulses on the system clock.
`include "dlc_cfg.svh"
`default_nettype none
module dlc_assembler #(
  parameter int WORD_W = `DLC_WORD_W,
  parameter int BYTE_W = `DLC_BYTE_W
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_byte_valid,
  input  wire logic              i_byte_high,
  input  wire logic [BYTE_W-1:0] i_byte,
  output logic      [WORD_W-1:0] o_word,
  output logic                   o_word_valid
);
  logic [WORD_W-1:0] word_ff;
  logic [WORD_W-1:0] nxt_word;
  logic              valid_ff;
  logic              nxt_valid;

  // Word completes only on the high byte, so a stray low byte is overwritten
  always_comb begin
    nxt_word  = word_ff;
    nxt_valid = 1'h0;
    if (i_byte_valid && !i_byte_high) begin
      nxt_word[BYTE_W-1:0] = i_byte;
    end else if (i_byte_valid) begin
      nxt_word[WORD_W-1:BYTE_W] = i_byte;
      nxt_valid                 = 1'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      word_ff  <= '0;
      valid_ff <= 1'h0;
    end else begin
      word_ff  <= nxt_word;
      valid_ff <= nxt_valid;
    end
  end

  assign o_word       = word_ff;
  assign o_word_valid = valid_ff;
endmodule
`default_nettype wire

// >>> rtl/dlc_writer.sv
// Host-side controller that writes 16-bit words into the converter latch.
// Assumes the converter pins are driven straight from these outputs.
`include "dlc_cfg.svh"
`default_nettype none
module dlc_writer #(
  parameter int SETUP_CYC = `DLC_SETUP_CYC,
  parameter int WRLOW_CYC = `DLC_WRLOW_CYC,
  parameter int HOLD_CYC  = `DLC_HOLD_CYC
) (
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_RESET,
  input  wire logic                   i_req,
  input  wire logic [`DLC_WORD_W-1:0] i_word,
  input  wire logic                   i_byte_valid,
  input  wire logic                   i_byte_high,
  input  wire logic [`DLC_BYTE_W-1:0] i_byte,
  input  wire logic                   i_offset_binary,
  output logic                        o_busy,
  output logic                        o_done,
  output logic      [`DLC_WORD_W-1:0] o_dac_data,
  output logic                        o_dac_cs_n,
  output logic                        o_dac_wr_n
);
  logic [`DLC_WORD_W-1:0] asm_word;
  logic                   asm_valid;

  dlc_assembler u_asm (
    .i_clock      (I_CLOCK),
    .i_reset      (I_RESET),
    .i_byte_valid (i_byte_valid),
    .i_byte_high  (i_byte_high),
    .i_byte       (i_byte),
    .o_word       (asm_word),
    .o_word_valid (asm_valid)
  );

  // Offset-binary users get the MSB flipped here, since the converter flips it back
  function automatic logic [`DLC_WORD_W-1:0] to_dac(
    input logic [`DLC_WORD_W-1:0] w,
    input logic                   ob
  );
    to_dac           = w;
    to_dac[`DLC_MSB] = w[`DLC_MSB] ^ ob;
  endfunction

  // Last cycle of a phase that lasts lim cycles
  function automatic logic phase_end(
    input logic [`DLC_CNT_W-1:0] cnt,
    input int                    lim
  );
    phase_end = (32'(cnt) + 32'h1) >= 32'(lim);
  endfunction

  // Strobe low time must cover both pulse width and data setup
  function automatic int low_cycles(
    input int setup,
    input int wrlow
  );
    low_cycles = (setup > wrlow) ? setup : wrlow;
  endfunction

  // Control group
  dlc_pkg::dlc_state_t    state_ff;
  dlc_pkg::dlc_state_t    nxt_state;
  logic [`DLC_CNT_W-1:0]  cnt_ff;
  logic [`DLC_CNT_W-1:0]  nxt_cnt;

  // Pin group
  logic [`DLC_WORD_W-1:0] data_ff;
  logic [`DLC_WORD_W-1:0] nxt_data;
  logic                   cs_n_ff;
  logic                   nxt_cs_n;
  logic                   wr_n_ff;
  logic                   nxt_wr_n;

  // Status group
  logic                   busy_ff;
  logic                   nxt_busy;
  logic                   done_ff;
  logic                   nxt_done;

  // Phase events shared by the control and pin groups; take also feeds the status group
  logic                   take;
  logic                   strb_end;
  logic                   hold_end;

  // Requests arriving while busy are dropped; caller waits on o_busy
  assign take     = (state_ff == dlc_pkg::DLC_IDLE) && (i_req || asm_valid);
  assign strb_end = (state_ff == dlc_pkg::DLC_STRB) && phase_end(cnt_ff, low_cycles(SETUP_CYC, WRLOW_CYC));
  assign hold_end = (state_ff == dlc_pkg::DLC_HOLD) && phase_end(cnt_ff, HOLD_CYC);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      dlc_pkg::DLC_IDLE: begin
        if (take) begin
          nxt_cnt   = '0;
          nxt_state = dlc_pkg::DLC_SETUP;
        end
      end
      dlc_pkg::DLC_SETUP: begin
        nxt_cnt   = '0;
        nxt_state = dlc_pkg::DLC_STRB;
      end
      dlc_pkg::DLC_STRB: begin
        nxt_cnt = cnt_ff + 1'h1;
        if (strb_end) begin
          nxt_cnt   = '0;
          nxt_state = dlc_pkg::DLC_HOLD;
        end
      end
      dlc_pkg::DLC_HOLD: begin
        nxt_cnt = cnt_ff + 1'h1;
        if (hold_end) begin
          nxt_state = dlc_pkg::DLC_DONE;
        end
      end
      dlc_pkg::DLC_DONE: begin
        nxt_state = dlc_pkg::DLC_IDLE;
      end
      default: begin
        nxt_state = dlc_pkg::DLC_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      state_ff <= dlc_pkg::DLC_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Pins change only at phase boundaries to keep digital noise off the ladder
  always_comb begin
    nxt_data = data_ff;
    nxt_cs_n = cs_n_ff;
    nxt_wr_n = wr_n_ff;
    case (state_ff)
      dlc_pkg::DLC_IDLE: begin
        if (take) begin
          nxt_data = to_dac(asm_valid ? asm_word : i_word, i_offset_binary);
          nxt_cs_n = 1'h0;
        end
      end
      dlc_pkg::DLC_SETUP: begin
        // Data settles one cycle before strobe falls, so no transparent glitch
        nxt_wr_n = 1'h0;
      end
      dlc_pkg::DLC_STRB: begin
        if (strb_end) begin
          nxt_wr_n = 1'h1;
        end
      end
      dlc_pkg::DLC_HOLD: begin
        // Data and select kept past the rising edge so the latch keeps this word
        if (hold_end) begin
          nxt_cs_n = 1'h1;
        end
      end
      dlc_pkg::DLC_DONE: begin
        nxt_cs_n = 1'h1;
        nxt_wr_n = 1'h1;
      end
      default: begin
        nxt_cs_n = 1'h1;
        nxt_wr_n = 1'h1;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      data_ff <= '0;
      cs_n_ff <= 1'h1;
      wr_n_ff <= 1'h1;
    end else begin
      data_ff <= nxt_data;
      cs_n_ff <= nxt_cs_n;
      wr_n_ff <= nxt_wr_n;
    end
  end

  always_comb begin
    nxt_busy = busy_ff;
    nxt_done = 1'h0;
    case (state_ff)
      dlc_pkg::DLC_IDLE: begin
        if (take) begin
          nxt_busy = 1'h1;
        end
      end
      dlc_pkg::DLC_SETUP, dlc_pkg::DLC_STRB, dlc_pkg::DLC_HOLD: begin
        nxt_busy = 1'h1;
      end
      dlc_pkg::DLC_DONE: begin
        nxt_busy = 1'h0;
        nxt_done = 1'h1;
      end
      default: begin
        nxt_busy = 1'h0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      busy_ff <= 1'h0;
      done_ff <= 1'h0;
    end else begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  // Correction and gain trim live inside the converter; host only supplies the word
  assign o_dac_data = data_ff;
  assign o_dac_cs_n = cs_n_ff;
  assign o_dac_wr_n = wr_n_ff;
  assign o_busy     = busy_ff;
  assign o_done     = done_ff;
endmodule
`default_nettype wire

// >>> tb/dlc_sva.sv
// Checker on the writer's converter pins; bound into the writer.
// Assumes the writer's strobe parameters are passed in by the bind.
`default_nettype none
module dlc_sva #(
  parameter int LOW_CYC = 2
) (
  input wire logic        I_CLOCK,
  input wire logic        I_RESET,
  input wire logic        o_done,
  input wire logic [15:0] o_dac_data,
  input wire logic        o_dac_cs_n,
  input wire logic        o_dac_wr_n);
  timeunit 1ns / 1ps;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  logic [7:0] low_cnt_ff;
  // Saturating count of strobe-low cycles, since a repetition cannot span 255 cycles
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || o_dac_wr_n) low_cnt_ff <= 8'h0;
    else if (low_cnt_ff != 8'hff) low_cnt_ff <= low_cnt_ff + 8'h1;
  end
  property p_sel; !o_dac_wr_n |-> !o_dac_cs_n; endproperty
  a_sel: assert property (p_sel) else $error("strobe alone");
  property p_stab; !o_dac_cs_n && !$past(o_dac_cs_n) |-> $stable(o_dac_data); endproperty
  a_stab: assert property (p_stab) else $error("data moved");
  property p_lead; $fell(o_dac_wr_n) |-> !$past(o_dac_cs_n); endproperty
  a_lead: assert property (p_lead) else $error("no lead");
  property p_low; $rose(o_dac_wr_n) |-> (32'(low_cnt_ff) + 32'h1) >= LOW_CYC; endproperty
  a_low: assert property (p_low) else $error("short strobe");
  property p_hold; $rose(o_dac_wr_n) |-> !o_dac_cs_n; endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_end; $rose(o_dac_cs_n) |-> !o_done ##1 o_done; endproperty
  a_end: assert property (p_end) else $error("late done");
  property p_once; o_done |=> !o_done; endproperty
  a_once: assert property (p_once) else $error("long done");
  property p_idle; o_done |-> o_dac_wr_n && $past(o_dac_cs_n) && !$past(o_dac_cs_n, 2); endproperty
  a_idle: assert property (p_idle) else $error("early done");
endmodule
bind dlc_writer dlc_sva #(.LOW_CYC((SETUP_CYC > WRLOW_CYC) ? SETUP_CYC : WRLOW_CYC)) u_sva (.I_CLOCK, .I_RESET,
  .o_done, .o_dac_data, .o_dac_cs_n, .o_dac_wr_n);
`default_nettype wire

// >>> tb/dlc_dac_model.sv
// Input latch of the converter; pins wired straight to the writer.
`default_nettype none
module dlc_dac_model (
  input  wire logic        i_cs_n,
  input  wire logic        i_wr_n,
  input  wire logic [15:0] i_data,
  output logic      [15:0] o_latch);
  timeunit 1ns / 1ps;
  always_latch if (!i_cs_n && !i_wr_n) o_latch <= i_data;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Bench for the writer; needs the writer, model and checker compiled first.
`default_nettype none
module testbench;
  timeunit 1ns / 1ps;
  logic clk = 0, rst = 1, req = 0, bv = 0, bh = 0, ob = 0, done, cs_n, wr_n, busy;
  int n_cycles = 0;
  logic [15:0] w = 16'h0, d, q;
  int n_errors = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  dlc_writer #(.SETUP_CYC(2), .WRLOW_CYC(2), .HOLD_CYC(1)) DUT (.I_CLOCK(clk), .I_RESET(rst), .i_req(req),
    .i_word(w), .i_byte_valid(bv), .i_byte_high(bh), .i_byte(w[7:0]), .i_offset_binary(ob), .o_busy(busy),
    .o_done(done), .o_dac_data(d), .o_dac_cs_n(cs_n), .o_dac_wr_n(wr_n));
  dlc_dac_model u_dac (.i_cs_n(cs_n), .i_wr_n(wr_n), .i_data(d), .o_latch(q));
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, v);
    num_checks++;
    if (v !== e) $display("wrong value %s expected %h seen %h", s, e, v);
    if (v !== e) n_errors++;
  endtask
  task automatic wait_done;
    repeat (40) if (done !== 1'b1) @(negedge clk);
    chk("done", 16'h1, {15'h0, done});
    chk("idle", 16'h0, {15'h0, busy});
  endtask
  task automatic go(input logic [15:0] x);
    w = x;
    req = 1;
    @(negedge clk);
    req = 0;
  endtask
  task automatic t_codes;
    for (int i = 0; i < 3; i++) begin
      go(16'h7fff + 16'(i));
      @(negedge clk);
      go(16'h0f0f);
      chk("open", 16'h7fff + 16'(i), q);
      chk("busy", 16'h1, {15'h0, busy});
      wait_done;
      chk("held", 16'h7fff + 16'(i), q);
    end
  endtask
  task automatic t_bytes;
    ob = 1;
    w = 16'h0034;
    bv = 1;
    @(negedge clk);
    w = 16'h0012;
    bh = 1;
    @(negedge clk);
    bv = 0;
    wait_done;
    chk("bytes", 16'h9234, q);
  endtask
  // Ceiling far above the 46 cycles the scenarios need
  always @(posedge clk) begin
    n_cycles++;
    if (n_cycles == 4000) begin
      $display("wrong value timeout expected %0d seen %0d", 3999, n_cycles);
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_codes;
    t_bytes;
    close_out;
  end
endmodule
`default_nettype wire
